// [eep_pkg.sv]
// Constants, timing counts and command tables for the parallel EEPROM host controller.
// Assumes a 200 MHz controller clock; all counts except the fixed BLC_GUARD and SYNC_STAGES derive from that rate.
package eep_pkg;

   // ---------------------------------------------------------------
   // Widths and field positions
   // ---------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CNT_W = 20;
   localparam int PAGE_ADDR_LOW_BIT = 7;
   localparam int PAGE_ADDR_HIGH_BIT = 14;
   localparam int COMPLEMENT_POLL_BIT = 7;
   localparam int TOGGLE_STATUS_BIT = 6;
   localparam logic [7:0] PAGE_BYTES = 8'h80;
   localparam logic [7:0] PCNT_RST = 8'h00;
   localparam logic [2:0] SEQ_UNLOCK_LEN = 3'h3;
   localparam logic [2:0] SEQ_RESET_LEN = 3'h6;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int SYNC_STAGES = 2;
   localparam int T_WP_NS = 50;
   localparam int T_WPH_NS = 50;
   localparam int T_ACC_NS = 150;
   localparam int T_BLC_US = 100;
   localparam int T_WC_MS = 5;
   localparam int T_DW_US = 10;
   // Least times round up, longest times round down
   localparam int T_WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
   localparam int T_ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int T_RD_CYC = T_ACC_CYC + SYNC_STAGES;
   localparam int BLC_CYC = T_BLC_US * CLK_MHZ;
   localparam int WC_CYC = T_WC_MS * 1000 * CLK_MHZ;
   localparam int DW_CYC = T_DW_US * CLK_MHZ;
   // Extra idle beyond the load window before polling starts
   localparam int BLC_GUARD = 16;
   localparam logic [CNT_W-1:0] WP_END = 20'(T_WP_CYC - 1);
   localparam logic [CNT_W-1:0] WPH_END = 20'(T_WPH_CYC - 1);
   localparam logic [CNT_W-1:0] RD_END = 20'(T_RD_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_RST = 20'h0_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 20'h0_0001;

   // ---------------------------------------------------------------
   // Operations and command sequences
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      EEP_OP_READ = 2'h0,
      EEP_OP_WRITE = 2'h1,
      EEP_OP_PWRITE = 2'h2,
      EEP_OP_UNPROT = 2'h3
   } eep_op_t;

   // Common byte-wide convention; change here to suit another part
   localparam logic [ADDR_W-1:0] CMD_ADDR_1 = 15'h5555;
   localparam logic [ADDR_W-1:0] CMD_ADDR_2 = 15'h2aaa;
   localparam logic [DATA_W-1:0] CMD_DATA_1 = 8'haa;
   localparam logic [DATA_W-1:0] CMD_DATA_2 = 8'h55;
   localparam logic [DATA_W-1:0] UNLOCK_DATA_3 = 8'ha0;
   localparam logic [DATA_W-1:0] RESET_DATA_3 = 8'h80;
   localparam logic [DATA_W-1:0] RESET_DATA_6 = 8'h20;

   function automatic logic [ADDR_W+DATA_W-1:0] eep_cmd_word(input logic is_reset, input logic [2:0] idx);
      logic [ADDR_W+DATA_W-1:0] w;
      w = {CMD_ADDR_1, CMD_DATA_1};
      case (idx)
         3'h0: w = {CMD_ADDR_1, CMD_DATA_1};
         3'h1: w = {CMD_ADDR_2, CMD_DATA_2};
         3'h2: w = is_reset ? {CMD_ADDR_1, RESET_DATA_3} : {CMD_ADDR_1, UNLOCK_DATA_3};
         3'h3: w = {CMD_ADDR_1, CMD_DATA_1};
         3'h4: w = {CMD_ADDR_2, CMD_DATA_2};
         3'h5: w = {CMD_ADDR_1, RESET_DATA_6};
         default: w = {CMD_ADDR_1, CMD_DATA_1};
      endcase
      return w;
   endfunction : eep_cmd_word

endpackage : eep_pkg

// [eep_sync.sv]
// Two-flop synchroniser for a bus of pin inputs.
// Assumes each bit is sampled independently; bus skew is covered by access margin.
`timescale 1ns/1ps
module eep_sync #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule : eep_sync

// [eep_host.sv]
// Host controller driving a parallel byte-alterable EEPROM through its pins.
// Assumes one 200 MHz clock; the data bus returns through eep_sync before use.
`timescale 1ns/1ps
module eep_host #(
   parameter int BLC_CYC = eep_pkg::BLC_CYC,
   parameter int WC_CYC = eep_pkg::WC_CYC,
   parameter int DW_CYC = eep_pkg::DW_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic [1:0] op_i,
   input wire logic [eep_pkg::ADDR_W-1:0] addr_i,
   input wire logic [eep_pkg::DATA_W-1:0] wdata_i,
   output logic ready_o,
   output logic ack_o,
   output logic busy_o,
   output logic [eep_pkg::DATA_W-1:0] rdata_o,
   output logic rvalid_o,
   output logic timeout_o,
   output logic chip_select_n_o,
   output logic output_enable_n_o,
   output logic write_strobe_n_o,
   output logic [eep_pkg::ADDR_W-1:0] addr_o,
   input wire logic [eep_pkg::DATA_W-1:0] dq_i,
   output logic [eep_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_o
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_WLO = 7'h02,
      ST_WHI = 7'h04,
      ST_PWAIT = 7'h08,
      ST_RD = 7'h10,
      ST_POLL = 7'h20,
      ST_DW = 7'h40
   } eep_state_t;

   localparam int PW = eep_pkg::PAGE_ADDR_HIGH_BIT - eep_pkg::PAGE_ADDR_LOW_BIT + 1;

   eep_state_t state_r, state_nxt;
   logic [eep_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic [eep_pkg::CNT_W-1:0] win_r, win_nxt;
   logic [eep_pkg::CNT_W-1:0] to_r, to_nxt;
   logic [eep_pkg::ADDR_W-1:0] addr_r, addr_nxt, tgt_addr_r, tgt_addr_nxt;
   logic [eep_pkg::DATA_W-1:0] data_r, data_nxt, tgt_data_r, tgt_data_nxt;
   logic [PW-1:0] page_r, page_nxt;
   logic [7:0] pcnt_r, pcnt_nxt;
   logic [2:0] seq_r, seq_nxt, seq_len_r, seq_len_nxt;
   logic seq_rst_r, seq_rst_nxt, pend_r, pend_nxt;
   logic polling_r, polling_nxt, ptog_r, ptog_nxt, pbit_r, pbit_nxt;
   logic [eep_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt, timeout_r, timeout_nxt;
   logic [eep_pkg::DATA_W-1:0] dq_sync;
   logic is_write_op, page_match, ready;
   logic [eep_pkg::ADDR_W+eep_pkg::DATA_W-1:0] cmd_w;

   // Pin data crosses into the clock domain before any decision
   eep_sync #(.W(eep_pkg::DATA_W)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(dq_i),
      .q_o(dq_sync)
   );

   // ---------------------------------------------------------------
   // Request acceptance
   // ---------------------------------------------------------------
   assign is_write_op = (op_i == eep_pkg::EEP_OP_WRITE) || (op_i == eep_pkg::EEP_OP_PWRITE);
   assign page_match = addr_i[eep_pkg::PAGE_ADDR_HIGH_BIT:eep_pkg::PAGE_ADDR_LOW_BIT] == page_r;
   // Extending a page needs same page, room left, and time before the window closes
   assign ready = (state_r == ST_IDLE) ||
                  ((state_r == ST_PWAIT) && is_write_op && page_match &&
                   (pcnt_r < eep_pkg::PAGE_BYTES) && (win_r < 20'(BLC_CYC - 2)));
   assign ready_o = ready;
   assign ack_o = req_i && ready;
   // Next command word from the registered index, so the next-state logic stays loop-free
   assign cmd_w = eep_pkg::eep_cmd_word(seq_rst_r, seq_r + 3'h1);

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + eep_pkg::CNT_ONE;
      win_nxt = (win_r == '1) ? win_r : win_r + eep_pkg::CNT_ONE;
      to_nxt = to_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      tgt_addr_nxt = tgt_addr_r;
      tgt_data_nxt = tgt_data_r;
      page_nxt = page_r;
      pcnt_nxt = pcnt_r;
      seq_nxt = seq_r;
      seq_len_nxt = seq_len_r;
      seq_rst_nxt = seq_rst_r;
      pend_nxt = pend_r;
      polling_nxt = polling_r;
      ptog_nxt = ptog_r;
      pbit_nxt = pbit_r;
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      timeout_nxt = timeout_r;
      case (state_r)
         ST_IDLE: begin
            if (req_i) begin
               timeout_nxt = 1'b0;
               tgt_addr_nxt = addr_i;
               tgt_data_nxt = wdata_i;
               cnt_nxt = eep_pkg::CNT_RST;
               seq_nxt = 3'h0;
               seq_len_nxt = 3'h0;
               seq_rst_nxt = (op_i == eep_pkg::EEP_OP_UNPROT);
               pend_nxt = (op_i == eep_pkg::EEP_OP_PWRITE);
               page_nxt = addr_i[eep_pkg::PAGE_ADDR_HIGH_BIT:eep_pkg::PAGE_ADDR_LOW_BIT];
               pcnt_nxt = eep_pkg::PCNT_RST;
               case (op_i)
                  eep_pkg::EEP_OP_READ: begin
                     addr_nxt = addr_i;
                     polling_nxt = 1'b0;
                     state_nxt = ST_RD;
                  end
                  eep_pkg::EEP_OP_WRITE: begin
                     addr_nxt = addr_i;
                     data_nxt = wdata_i;
                     win_nxt = eep_pkg::CNT_RST;
                     state_nxt = ST_WLO;
                  end
                  default: begin
                     // Unlock ahead of every protected burst, reset sequence for unprotect
                     seq_len_nxt = (op_i == eep_pkg::EEP_OP_UNPROT) ? eep_pkg::SEQ_RESET_LEN :
                                                                     eep_pkg::SEQ_UNLOCK_LEN;
                     {addr_nxt, data_nxt} = eep_pkg::eep_cmd_word(op_i == eep_pkg::EEP_OP_UNPROT, 3'h0);
                     win_nxt = eep_pkg::CNT_RST;
                     state_nxt = ST_WLO;
                  end
               endcase
            end
         end
         ST_WLO: begin
            if (cnt_r == eep_pkg::WP_END) begin
               cnt_nxt = eep_pkg::CNT_RST;
               state_nxt = ST_WHI;
            end
         end
         ST_WHI: begin
            if (cnt_r == eep_pkg::WPH_END) begin
               cnt_nxt = eep_pkg::CNT_RST;
               if (seq_len_r != 3'h0 && seq_r + 3'h1 < seq_len_r) begin
                  // Command writes follow back to back, no other cycles between
                  seq_nxt = seq_r + 3'h1;
                  {addr_nxt, data_nxt} = cmd_w;
                  win_nxt = eep_pkg::CNT_RST;
                  state_nxt = ST_WLO;
               end else if (seq_len_r != 3'h0) begin
                  seq_len_nxt = 3'h0;
                  if (pend_r) begin
                     pend_nxt = 1'b0;
                     addr_nxt = tgt_addr_r;
                     data_nxt = tgt_data_r;
                     win_nxt = eep_pkg::CNT_RST;
                     state_nxt = ST_WLO;
                  end else begin
                     // Reset sequence done; poll the toggle bit until programming ends
                     to_nxt = eep_pkg::CNT_RST;
                     ptog_nxt = 1'b0;
                     state_nxt = ST_POLL;
                  end
               end else begin
                  pcnt_nxt = pcnt_r + 8'h01;
                  state_nxt = ST_PWAIT;
               end
            end
         end
         ST_PWAIT: begin
            if (req_i && ready) begin
               addr_nxt = addr_i;
               data_nxt = wdata_i;
               cnt_nxt = eep_pkg::CNT_RST;
               win_nxt = eep_pkg::CNT_RST;
               state_nxt = ST_WLO;
            end else if (win_r >= 20'(BLC_CYC + eep_pkg::BLC_GUARD)) begin
               // Polling before the device closes the page could see a false stable bit
               to_nxt = eep_pkg::CNT_RST;
               ptog_nxt = 1'b0;
               cnt_nxt = eep_pkg::CNT_RST;
               state_nxt = ST_POLL;
            end
         end
         ST_POLL: begin
            to_nxt = to_r + eep_pkg::CNT_ONE;
            if (to_r >= 20'(WC_CYC)) begin
               timeout_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end else if (cnt_r == eep_pkg::WPH_END) begin
               cnt_nxt = eep_pkg::CNT_RST;
               polling_nxt = 1'b1;
               state_nxt = ST_RD;
            end
         end
         ST_RD: begin
            to_nxt = to_r + eep_pkg::CNT_ONE;
            // Full access time plus synchroniser delay before sampling
            if (cnt_r == eep_pkg::RD_END) begin
               cnt_nxt = eep_pkg::CNT_RST;
               if (!polling_r) begin
                  rdata_nxt = dq_sync;
                  rvalid_nxt = 1'b1;
                  state_nxt = ST_IDLE;
               end else if (ptog_r && dq_sync[eep_pkg::TOGGLE_STATUS_BIT] == pbit_r) begin
                  state_nxt = ST_DW;
               end else begin
                  ptog_nxt = 1'b1;
                  pbit_nxt = dq_sync[eep_pkg::TOGGLE_STATUS_BIT];
                  state_nxt = ST_POLL;
               end
            end
         end
         ST_DW: begin
            if (cnt_r >= 20'(DW_CYC - 1)) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         cnt_r <= eep_pkg::CNT_RST;
         win_r <= eep_pkg::CNT_RST;
         to_r <= eep_pkg::CNT_RST;
         addr_r <= '0;
         data_r <= '0;
         tgt_addr_r <= '0;
         tgt_data_r <= '0;
         page_r <= '0;
         pcnt_r <= eep_pkg::PCNT_RST;
         seq_r <= 3'h0;
         seq_len_r <= 3'h0;
         seq_rst_r <= 1'b0;
         pend_r <= 1'b0;
         polling_r <= 1'b0;
         ptog_r <= 1'b0;
         pbit_r <= 1'b0;
         rdata_r <= '0;
         rvalid_r <= 1'b0;
         timeout_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         win_r <= win_nxt;
         to_r <= to_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         tgt_addr_r <= tgt_addr_nxt;
         tgt_data_r <= tgt_data_nxt;
         page_r <= page_nxt;
         pcnt_r <= pcnt_nxt;
         seq_r <= seq_nxt;
         seq_len_r <= seq_len_nxt;
         seq_rst_r <= seq_rst_nxt;
         pend_r <= pend_nxt;
         polling_r <= polling_nxt;
         ptog_r <= ptog_nxt;
         pbit_r <= pbit_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         timeout_r <= timeout_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   // Strobes decode single one-hot bits, chip select the OR of two; write phase never overlaps a read phase
   assign chip_select_n_o = ~(state_r[1] | state_r[4]);
   assign write_strobe_n_o = ~state_r[1];
   assign output_enable_n_o = ~state_r[4];
   assign dq_oe_o = state_r[1] | state_r[2];
   assign dq_o = data_r;
   assign addr_o = addr_r;
   assign busy_o = (state_r != ST_IDLE);
   assign rdata_o = rdata_r;
   assign rvalid_o = rvalid_r;
   assign timeout_o = timeout_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   write_combo_a: assert property (!write_strobe_n_o |-> !chip_select_n_o && output_enable_n_o)
      else $error("write strobe low without select or with enable low");
   page_same_a: assert property ((state_r == ST_WLO) && (seq_len_r == 3'h0) && !pend_r |->
                                 addr_o[eep_pkg::PAGE_ADDR_HIGH_BIT:eep_pkg::PAGE_ADDR_LOW_BIT] == page_r)
      else $error("page address changed inside a page load");
   page_count_a: assert property ($rose(state_r == ST_PWAIT) |-> pcnt_r <= eep_pkg::PAGE_BYTES && pcnt_r != 8'h00)
      else $error("page byte count out of range");
   load_window_a: assert property ($fell(write_strobe_n_o) && $past(state_r == ST_PWAIT) |->
                                   $past(win_r) < 20'(BLC_CYC))
      else $error("byte load started after the load window");
   unlock_first_a: assert property ((state_r == ST_WHI) && (cnt_r == eep_pkg::WPH_END) && (seq_len_r == 3'h3) &&
                                    (seq_r == 3'h2) |=> (state_r == ST_WLO) && (addr_o == tgt_addr_r))
      else $error("protected data write did not follow the unlock");
   cmd_table_a: assert property ((state_r == ST_WLO) && (seq_len_r != 3'h0) |->
                                 {addr_o, dq_o} == eep_pkg::eep_cmd_word(seq_rst_r, seq_r))
      else $error("command write carries the wrong address or data");
   seq_start_a: assert property ((state_r == ST_WLO) && (seq_len_r != 3'h0) && (seq_r == 3'h0) |->
                                 addr_o == 15'h5555 && dq_o == 8'haa)
      else $error("command sequence does not open with the default word");
   seq_gapless_a: assert property ((state_r == ST_WHI) && (cnt_r == eep_pkg::WPH_END) && (seq_len_r != 3'h0) &&
                                   !(seq_rst_r && seq_r == 3'h5) |=> $fell(write_strobe_n_o))
      else $error("command sequence interrupted");
   read_time_a: assert property ($rose(output_enable_n_o) |-> $past(cnt_r) == eep_pkg::RD_END)
      else $error("read cycle shorter than the access time");
   reset_six_a: assert property ((state_r == ST_WHI) && (cnt_r == eep_pkg::WPH_END) && seq_rst_r &&
                                 (seq_len_r == 3'h6) && (seq_r == 3'h5) |=> state_r == ST_POLL)
      else $error("reset sequence did not end after six writes");

   read_c: cover property ((state_r == ST_RD) && !polling_r ##1 rvalid_o);
   page_c: cover property ($rose(state_r == ST_PWAIT) && pcnt_r == 8'h02);
   prot_c: cover property ((state_r == ST_WLO) && pend_r && seq_r == 3'h2);
   poll_done_c: cover property ((state_r == ST_RD) ##1 (state_r == ST_DW));
endmodule : eep_host

// [eep_dev_model.sv]
// Behavioural byte-wide EEPROM as seen from the host's pins.
// Assumes the host clock serves as time base for load window, programming and the released-bus pattern.
`timescale 1ns/1ps
module eep_dev_model #(
   parameter int BLC = 200,
   parameter int WCS = 1000
) (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic cs_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [14:0] addr_i,
   input wire logic [7:0] dq_i,
   output logic [7:0] dq_o
);
   localparam logic [22:0] W1 = {eep_pkg::CMD_ADDR_1, eep_pkg::CMD_DATA_1};
   localparam logic [22:0] W2 = {eep_pkg::CMD_ADDR_2, eep_pkg::CMD_DATA_2};
   localparam logic [22:0] W3 = {eep_pkg::CMD_ADDR_1, eep_pkg::UNLOCK_DATA_3};
   localparam logic [22:0] R3 = {eep_pkg::CMD_ADDR_1, eep_pkg::RESET_DATA_3};
   localparam logic [22:0] R6 = {eep_pkg::CMD_ADDR_1, eep_pkg::RESET_DATA_6};
   logic [7:0] mem [32768];
   logic [14:0] pa [$];
   logic [7:0] pd [$];
   logic [22:0] h [6];
   logic [14:0] la;
   logic [7:0] ld, cyc = 8'h00;
   logic prot = 1'b0, unl = 1'b0, clr = 1'b0, busy = 1'b0, tg = 1'b0;
   int idle = 0, prog = 0;
   wire wr = cs_n_i | we_n_i | !oe_n_i;
   wire rd = cs_n_i | oe_n_i;
   initial foreach (mem[i]) mem[i] = 8'hff;
   always @(negedge wr) if ($time > 0) begin
      la = addr_i;
      idle = 0;
   end
   // Locked or mid-programming writes never reach the page
   always @(posedge wr) if ($time > 0 && !busy) begin
      ld = dq_i;
      for (int i = 0; i < 5; i++) h[i] = h[i + 1];
      h[5] = {la, ld};
      if (!prot || unl) pa.push_back(la);
      if (!prot || unl) pd.push_back(ld);
      if ({h[3], h[4], h[5]} == {W1, W2, W3}) begin
         unl = 1'b1;
         pa.delete();
         pd.delete();
      end
      if ({h[0], h[1], h[2]} == {W1, W2, R3} && {h[3], h[4], h[5]} == {W1, W2, R6}) begin
         clr = 1'b1;
         idle = BLC;
         pa.delete();
         pd.delete();
      end
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 8'h01;
      if (busy) begin
         prog = prog - 1;
         if (prog == 0) begin
            foreach (pa[i]) mem[pa[i]] = pd[i];
            if (unl) prot = 1'b1;
            if (clr) prot = 1'b0;
            {unl, clr, busy} = 3'b000;
            pa.delete();
            pd.delete();
         end
      end else if ((pa.size() > 0 || clr) && ++idle >= BLC) begin
         busy = 1'b1;
         prog = slow_i ? 6 * WCS : WCS;
      end
   end
   always @(posedge rd) if (busy) tg = !tg;
   // Released bus moves every cycle so a stale value cannot pass
   assign dq_o = rd ? cyc ^ 8'h5a : busy ? {~ld[7], tg, ld[5:0]} : mem[addr_i];
endmodule : eep_dev_model

// [tb_eep_host.sv]
// Self-checking bench for the EEPROM host controller against a device model.
// Assumes shortened window, programming and settle counts.
`timescale 1ns/1ps
module tb_eep_host;
   logic clk = 1'b0, rst = 1'b1, req = 1'b0, slow = 1'b0;
   logic [1:0] opc = 2'h0;
   logic [14:0] addr = 15'h0000, pa;
   logic [7:0] wd = 8'h00, rdata, hd, md;
   logic rdy, ack, busy, rvalid, tmo, cs_n, oe_n, we_n, oe;
   wire [7:0] bus = oe ? hd : md;
   int error_cnt = 0, compares = 0;
   eep_host #(.BLC_CYC(200), .WC_CYC(4000), .DW_CYC(20)) i_eep_host (.clk_i(clk), .rst_i(rst), .req_i(req),
      .op_i(opc), .addr_i(addr), .wdata_i(wd), .ready_o(rdy), .ack_o(ack), .busy_o(busy), .rdata_o(rdata),
      .rvalid_o(rvalid), .timeout_o(tmo), .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
      .write_strobe_n_o(we_n), .addr_o(pa), .dq_i(bus), .dq_o(hd), .dq_oe_o(oe));
   eep_dev_model #(.BLC(200), .WCS(1000)) i_eep_dev_model (.clk_i(clk), .slow_i(slow), .cs_n_i(cs_n),
      .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(pa), .dq_i(bus), .dq_o(md));
   initial forever #2.5 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   // Request is left up so page bytes follow back to back
   task automatic op(input logic [1:0] o, input logic [14:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req <= 1'b1;
      opc <= o;
      addr <= a;
      wd <= d;
      do begin
         @(negedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         error_cnt++;
         $display("ERROR %0t request never taken", $time);
      end
      @(posedge clk);
   endtask : op
   task automatic wait_idle();
      int n;
      n = 0;
      req <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (busy !== 1'b0 && n < 20000);
      if (n >= 20000) begin
         error_cnt++;
         $display("ERROR %0t controller never idle", $time);
      end
      @(posedge clk);
   endtask : wait_idle
   task automatic rd(input logic [14:0] a, input logic [7:0] exp);
      int n;
      n = 0;
      op(2'h0, a, 8'h00);
      req <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (rvalid !== 1'b1 && n < 100);
      chk(8'(n), 8'h21);
      chk(rdata, exp);
      @(posedge clk);
   endtask : rd
   task automatic s_byte();
      op(2'h1, 15'h0123, 8'h3c);
      @(negedge clk);
      chk({3'h0, rdy, oe, cs_n, oe_n, we_n}, 8'h0a);
      chk(hd, 8'h3c);
      chk(pa[7:0], 8'h23);
      @(posedge clk);
      wait_idle();
      chk({7'h00, tmo}, 8'h00);
      rd(15'h0123, 8'h3c);
   endtask : s_byte
   task automatic s_page();
      for (int i = 0; i < 128; i++) op(2'h1, 15'h0100 + 15'(i), 8'(i) ^ 8'ha5);
      wait_idle();
      rd(15'h0100, 8'ha5);
      rd(15'h017f, 8'h7f ^ 8'ha5);
   endtask : s_page
   task automatic s_prot();
      op(2'h2, 15'h0200, 8'h77);
      wait_idle();
      rd(15'h0200, 8'h77);
      op(2'h1, 15'h0200, 8'h11);
      wait_idle();
      rd(15'h0200, 8'h77);
      op(2'h3, 15'h0000, 8'h00);
      wait_idle();
      op(2'h1, 15'h0200, 8'h22);
      wait_idle();
      rd(15'h0200, 8'h22);
   endtask : s_prot
   // Programming outlasts the host's limit; model must settle before reuse
   task automatic s_slow();
      slow <= 1'b1;
      op(2'h1, 15'h0300, 8'h5a);
      wait_idle();
      chk({7'h00, tmo}, 8'h01);
      slow <= 1'b0;
      repeat (3000) @(posedge clk);
      rd(15'h0300, 8'h5a);
      chk({7'h00, tmo}, 8'h00);
   endtask : s_slow
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({5'h00, cs_n, oe_n, we_n}, 8'h07);
      chk({6'h00, oe, busy}, 8'h00);
      @(posedge clk);
      s_byte();
      s_page();
      s_prot();
      s_slow();
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("ERROR %0t watchdog expired", $time);
      stop_test();
   end
endmodule : tb_eep_host
